// ==== rtl/rss_reset_source_sequencer.sv ====
`default_nettype none
module rss_reset_source_sequencer #(
   parameter int POWERUP_TIMER_COUNT = rss_pkg::POWERUP_TIMER_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire rss_pkg::rss_cfg_type cfg_i,
   input wire rss_pkg::rss_event_type evt_i,
   input wire logic ext_reset_pin_i,
   input wire logic [14:0] pc_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic core_reset_o,
   output logic cpu_run_o,
   output logic pc_load_o,
   output logic [14:0] pc_o,
   output logic push_return_o,
   output logic pin_pullup_o,
   output logic pin_drive_low_o,
   output logic bor_active_o
);
   import rss_pkg::*;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10,
      ST_SLEEP = 2'b11
   } rss_state_type;

   rss_state_type state;
   logic sw_brownout_enable;
   logic brownout_ready_flag;
   logic pullup_sw;
   logic [7:0] reset_cause_reg;
   logic timeout_flag;
   logic powerdown_flag;
   logic [31:0] powerup_timer_cnt;
   logic [7:0] filt_cnt;
   logic pin_low_filt;
   logic [3:0] rel_cnt;
   logic last_was_power;
   logic pin_en;
   logic bor_en;
   logic low_power_brownout_trip;
   logic bor_trip;
   logic generic_bor;
   logic wdt_rst;
   logic stack_rst;
   logic soft_rst;
   logic any_rst;
   logic wait_bor;
   logic powerup_timer_done;
   logic start_ok;

   assign pin_en = cfg_i.ext_reset_pin_enable | cfg_i.low_voltage_prog_enable;

   always_comb
   begin
      case (cfg_i.brownout_mode_cfg)
         BOR_MODE_ON: bor_en = 1'b1;
         BOR_MODE_NOSLEEP: bor_en = (state != ST_SLEEP);
         BOR_MODE_SW: bor_en = sw_brownout_enable;
         default: bor_en = 1'b0;
      endcase
   end

   // Main detector only protects once it reports ready
   assign bor_trip = bor_en & evt_i.bor_ready & evt_i.bor_trip;
   assign low_power_brownout_trip = cfg_i.low_power_brownout_en & evt_i.low_power_brownout_trip;
   assign generic_bor = bor_trip | low_power_brownout_trip;
   assign wdt_rst = evt_i.watchdog_timeout & (state != ST_SLEEP);
   assign stack_rst = cfg_i.stack_reset_enable
      & (evt_i.stack_overflow | evt_i.stack_underflow);
   assign soft_rst = wdt_rst | evt_i.reset_instr | stack_rst | evt_i.prog_exit;
   assign any_rst = evt_i.por | generic_bor | soft_rst | pin_low_filt;
   assign powerup_timer_done = ~cfg_i.powerup_timer_disable_n | (powerup_timer_cnt == 32'(POWERUP_TIMER_COUNT));

   always_comb
   begin
      case (cfg_i.brownout_mode_cfg)
         BOR_MODE_NOSLEEP: wait_bor = 1'b1;
         BOR_MODE_SW: wait_bor = sw_brownout_enable | last_was_power;
         default: wait_bor = 1'b0;
      endcase
   end

   assign start_ok = ~wait_bor | (evt_i.bor_ready & ~evt_i.bor_trip);

   // Pin noise filter: low must persist before reset is taken
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         filt_cnt <= 8'h00;
         pin_low_filt <= 1'b0;
      end
      else if (!pin_en || ext_reset_pin_i)
      begin
         filt_cnt <= 8'h00;
         pin_low_filt <= 1'b0;
      end
      else if (filt_cnt == 8'(FILTER_CYCLES))
         pin_low_filt <= 1'b1;
      else
         filt_cnt <= filt_cnt + 8'h01;
   end

   // Power-up timer runs regardless of the pin
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         powerup_timer_cnt <= 32'h0;
      else if (evt_i.por || generic_bor)
         powerup_timer_cnt <= 32'h0;
      else if (powerup_timer_cnt != 32'(POWERUP_TIMER_COUNT))
         powerup_timer_cnt <= powerup_timer_cnt + 32'h1;
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state <= ST_RESET;
         rel_cnt <= 4'h0;
         core_reset_o <= 1'b1;
         cpu_run_o <= 1'b0;
      end
      else
      begin
         case (state)
            ST_RESET:
            begin
               rel_cnt <= 4'h0;
               if (!any_rst)
                  state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (any_rst)
                  state <= ST_RESET;
               else if (powerup_timer_done && evt_i.ost_done && start_ok)
               begin
                  if (rel_cnt == 4'(RELEASE_CYCLES - 1))
                     state <= ST_RUN;
                  else
                     rel_cnt <= rel_cnt + 4'h1;
               end
            end
            ST_RUN:
            begin
               if (any_rst)
                  state <= ST_RESET;
               else if (evt_i.sleep)
                  state <= ST_SLEEP;
            end
            default:
            begin
               if (any_rst)
                  state <= ST_RESET;
               else if ((evt_i.wake_wdt || evt_i.wake_irq) && start_ok)
                  state <= ST_RUN;
            end
         endcase
         // Core stays held through the whole start-up wait
         core_reset_o <= any_rst | (state == ST_RESET) | (state == ST_WAIT);
         cpu_run_o <= (state == ST_RUN) & ~any_rst;
      end
   end

   // Flags: other resets change only their own cause; power-on and brown-out also rewrite the other cause bits, except bit 0 on power-on and bit 1 on brown-out
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         reset_cause_reg <= CAUSE_RESET_VAL;
         {timeout_flag, powerdown_flag} <= STATUS_RESET_VAL;
         last_was_power <= 1'b1;
      end
      else if (evt_i.por)
      begin
         reset_cause_reg <= {2'b00, 1'b0, 3'b111, 1'b0, reset_cause_reg[0]};
         {timeout_flag, powerdown_flag} <= 2'b11;
         last_was_power <= 1'b1;
      end
      else if (generic_bor)
      begin
         reset_cause_reg <= {2'b00, 1'b0, 1'b1, 2'b11, reset_cause_reg[1], 1'b0};
         {timeout_flag, powerdown_flag} <= 2'b11;
         last_was_power <= 1'b1;
      end
      else
      begin
         if (wr_i && addr_i == ADDR_RESET_CAUSE)
            reset_cause_reg <= {wdata_i[7:6], 1'b0, wdata_i[4:0]};
         if (wr_i && addr_i == ADDR_STATUS)
            {timeout_flag, powerdown_flag} <= wdata_i[1:0];
         // Hardware events win over a same-cycle software write
         if (evt_i.stack_overflow && stack_rst)
            reset_cause_reg[7] <= 1'b1;
         if (evt_i.stack_underflow && stack_rst)
            reset_cause_reg[6] <= 1'b1;
         if (wdt_rst)
         begin
            reset_cause_reg[4] <= 1'b0;
            timeout_flag <= 1'b0;
         end
         if (pin_low_filt && state != ST_RESET)
         begin
            reset_cause_reg[3] <= 1'b0;
            if (state == ST_SLEEP)
            begin
               timeout_flag <= 1'b1;
               powerdown_flag <= 1'b0;
            end
         end
         if (evt_i.reset_instr)
            reset_cause_reg[2] <= 1'b0;
         if (state == ST_RUN && evt_i.sleep)
         begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
         end
         if (state == ST_SLEEP && evt_i.wake_wdt)
         begin
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
         end
         if (soft_rst || pin_low_filt)
            last_was_power <= 1'b0;
      end
   end

   // Program counter result
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pc_o <= PC_RESET_VEC;
         pc_load_o <= 1'b0;
         push_return_o <= 1'b0;
      end
      else if (state == ST_WAIT && !any_rst && powerup_timer_done && evt_i.ost_done && start_ok
               && rel_cnt == 4'(RELEASE_CYCLES - 1))
      begin
         pc_o <= PC_RESET_VEC;
         pc_load_o <= 1'b1;
         push_return_o <= 1'b0;
      end
      else if (state == ST_SLEEP && !any_rst && start_ok
               && (evt_i.wake_wdt || evt_i.wake_irq))
      begin
         pc_load_o <= 1'b1;
         if (evt_i.wake_irq && evt_i.global_irq_enable)
         begin
            pc_o <= PC_IRQ_VEC;
            push_return_o <= 1'b1;
         end
         else
         begin
            pc_o <= 15'(pc_i + 15'h1);
            push_return_o <= 1'b0;
         end
      end
      else
      begin
         pc_load_o <= 1'b0;
         push_return_o <= 1'b0;
      end
   end

   // Brownout control and pull-up registers
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sw_brownout_enable <= 1'b1;
         pullup_sw <= 1'b0;
      end
      else if (wr_i && addr_i == ADDR_BROWNOUT_CTRL)
         sw_brownout_enable <= wdata_i[BIT_SW_BROWNOUT_ENABLE];
      else if (wr_i && addr_i == ADDR_CONFIG)
         pullup_sw <= wdata_i[0];
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         brownout_ready_flag <= 1'b0;
         bor_active_o <= 1'b0;
         pin_pullup_o <= 1'b1;
         pin_drive_low_o <= 1'b0;
      end
      else
      begin
         brownout_ready_flag <= bor_en & evt_i.bor_ready;
         bor_active_o <= bor_en & evt_i.bor_ready;
         pin_pullup_o <= pin_en | pullup_sw;
         pin_drive_low_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         rdata_o <= 8'h00;
      else if (!rd_i)
         rdata_o <= 8'h00;
      else if (addr_i == ADDR_BROWNOUT_CTRL)
         rdata_o <= {sw_brownout_enable, 6'h00, brownout_ready_flag};
      else if (addr_i == ADDR_RESET_CAUSE)
         rdata_o <= reset_cause_reg;
      else if (addr_i == ADDR_STATUS)
         rdata_o <= {6'h00, timeout_flag, powerdown_flag};
      else if (addr_i == ADDR_CONFIG)
         rdata_o <= {7'h00, pullup_sw};
      else
         rdata_o <= 8'h00;
   end
endmodule // rss_reset_source_sequencer
`default_nettype wire

// ==== rtl/rss_pkg.sv ====
`default_nettype none
package rss_pkg;
   localparam logic [1:0] BOR_MODE_OFF = 2'b00;
   localparam logic [1:0] BOR_MODE_SW = 2'b01;
   localparam logic [1:0] BOR_MODE_NOSLEEP = 2'b10;
   localparam logic [1:0] BOR_MODE_ON = 2'b11;
   localparam int CLK_MHZ = 200;
   localparam int POWERUP_TIMER_MS = 64;
   localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
   localparam int FILTER_NS = 50;
   localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int RELEASE_CYCLES = 10;
   localparam logic [3:0] ADDR_BROWNOUT_CTRL = 4'h0;
   localparam logic [3:0] ADDR_RESET_CAUSE = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_CONFIG = 4'h3;
   // Unimplemented bit 5 reads as zero
   localparam logic [7:0] CAUSE_RESET_VAL = 8'h1c;
   localparam logic [1:0] STATUS_RESET_VAL = 2'h3;
   localparam logic [14:0] PC_RESET_VEC = 15'h0000;
   localparam logic [14:0] PC_IRQ_VEC = 15'h0004;
   localparam int BIT_SW_BROWNOUT_ENABLE = 7;
   localparam int BIT_RDY = 0;
   typedef struct packed {
      logic [1:0] brownout_mode_cfg;
      logic low_power_brownout_en;
      logic ext_reset_pin_enable;
      logic low_voltage_prog_enable;
      logic stack_reset_enable;
      logic powerup_timer_disable_n;
      logic ost_required;
   } rss_cfg_type;
   typedef struct packed {
      logic por;
      logic bor_trip;
      logic bor_ready;
      logic low_power_brownout_trip;
      logic watchdog_timeout;
      logic reset_instr;
      logic stack_overflow;
      logic stack_underflow;
      logic prog_exit;
      logic sleep;
      logic wake_wdt;
      logic wake_irq;
      logic global_irq_enable;
      logic ost_done;
   } rss_event_type;
endpackage : rss_pkg
`default_nettype wire

// ==== test/rss_chk.sv ====
`default_nettype none
module rss_chk import rss_pkg::*; (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire rss_pkg::rss_cfg_type cfg_i,
   input wire rss_pkg::rss_event_type evt_i,
   input wire logic ext_reset_pin_i,
   input wire logic [3:0] addr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic core_reset_o,
   input wire logic cpu_run_o,
   input wire logic pc_load_o,
   input wire logic [14:0] pc_o,
   input wire logic pin_drive_low_o,
   input wire logic bor_active_o
);
   logic pin_en;
   logic [4:0] pin_lo;
   logic [4:0] pin_hi;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   assign pin_en = cfg_i.ext_reset_pin_enable | cfg_i.low_voltage_prog_enable;
   // Saturating run lengths of the raw pin level
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pin_lo <= 5'h00;
         pin_hi <= 5'h00;
      end
      else
      begin
         pin_lo <= ext_reset_pin_i ? 5'h00 : pin_lo + 5'(pin_lo != 5'h1f);
         pin_hi <= ext_reset_pin_i ? pin_hi + 5'(pin_hi != 5'h1f) : 5'h00;
      end
   end
   a_pin_holds: assert property (pin_en && pin_lo == 5'd14 |-> ##[0:3] core_reset_o)
      else $error("pin low did not hold reset");
   a_run_after_pin: assert property (pin_en && $rose(cpu_run_o) |-> pin_hi >= 5'd10)
      else $error("run started too soon after pin release");
   a_pin_never_low: assert property (!pin_drive_low_o)
      else $error("pin driven low");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data without read");
   a_unmapped_zero: assert property (rd_i && addr_i > ADDR_CONFIG |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_reset_vector: assert property (pc_load_o && core_reset_o |-> pc_o == PC_RESET_VEC)
      else $error("start vector wrong");
   a_run_excl_reset: assert property (cpu_run_o |-> !core_reset_o)
      else $error("run while core held");
   a_por_holds: assert property (evt_i.por |-> ##[0:2] core_reset_o)
      else $error("power-on did not hold core");
   a_load_pulse: assert property (pc_load_o |=> !pc_load_o)
      else $error("pc load longer than a cycle");
   a_bor_off: assert property ((cfg_i.brownout_mode_cfg == BOR_MODE_OFF
      && !cfg_i.low_power_brownout_en) [*2] |-> !bor_active_o)
      else $error("brown-out active in off mode");
   c_run: cover property ($rose(cpu_run_o));
   c_pin: cover property (pin_en && pin_lo == 5'd14);
   c_unmapped: cover property (rd_i && addr_i > ADDR_CONFIG);
endmodule // rss_chk
`default_nettype wire

// ==== test/rss_reset_source_sequencer_bench.sv ====
`default_nettype none
bind rss_reset_source_sequencer rss_chk chk (.clk_sys_i, .reset_i, .cfg_i, .evt_i,
   .ext_reset_pin_i, .addr_i, .rd_i, .rdata_o, .core_reset_o, .cpu_run_o, .pc_load_o,
   .pc_o, .pin_drive_low_o, .bor_active_o);
module rss_reset_source_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import rss_pkg::*;
   localparam int POWERUP_TIMER_SIM = 20;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   rss_cfg_type cfg_i;
   rss_event_type evt_i, idle, e;
   logic ext_reset_pin_i = 1'b1;
   logic [14:0] pc_i = 15'h0123;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o, d;
   logic core_reset_o, cpu_run_o, pc_load_o, push_return_o, pin_pullup_o, pin_drive_low_o;
   logic bor_active_o;
   logic [14:0] pc_o;
   logic [7:0] exp_c [7] = '{8'h1b, 8'h9f, 8'h5f, 8'h0f, 8'h1e, 8'h1e, 8'h1d};
   logic [7:0] exp_s [7] = '{8'h03, 8'h03, 8'h03, 8'h01, 8'h03, 8'h03, 8'h03};
   // Mode, software enable, sleep, expected protection
   logic [4:0] modes [6] = '{5'b11111, 5'b10101, 5'b10110, 5'b01101, 5'b01000, 5'b00100};
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   rss_reset_source_sequencer #(.POWERUP_TIMER_COUNT(POWERUP_TIMER_SIM)) dut (.clk_sys_i, .reset_i, .cfg_i,
      .evt_i, .ext_reset_pin_i, .pc_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .core_reset_o, .cpu_run_o, .pc_load_o, .pc_o, .push_return_o, .pin_pullup_o,
      .pin_drive_low_o, .bor_active_o);
   initial
   begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic give_verdict();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      step(1);
      wr_i <= 1'b0;
      step(1);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] v);
      addr_i <= a;
      rd_i <= 1'b1;
      step(1);
      rd_i <= 1'b0;
      #1 cmp(rdata_o, v);
      step(1);
   endtask
   // Bounded wait; start-up counts vary with the timers
   task automatic wait_run();
      n = 0;
      while (cpu_run_o !== 1'b1 && n < 400)
      begin
         step(1);
         n++;
      end
   endtask
   task automatic hold(input rss_event_type ev);
      evt_i <= idle | ev;
      step(4);
      cmp({7'h00, core_reset_o}, 8'h01);
      evt_i <= idle;
      step(1);
      wait_run();
   endtask
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   initial
   begin
      idle = '0;
      idle.ost_done = 1'b1;
      idle.bor_ready = 1'b1;
      evt_i = idle;
      cfg_i = '0;
      cfg_i.ext_reset_pin_enable = 1'b1;
      cfg_i.stack_reset_enable = 1'b1;
      void'($urandom(32'he354));
      step(16);
      reset_i <= 1'b0;
      wait_run();
      cmp({7'h00, cpu_run_o}, 8'h01);
      rd_chk(ADDR_RESET_CAUSE, CAUSE_RESET_VAL);
      rd_chk(ADDR_STATUS, 8'h03);
      rd_chk(4'hf, 8'h00);
      repeat (6)
      begin
         d = 8'($urandom);
         pc_i <= 15'($urandom);
         wr_reg(ADDR_RESET_CAUSE, d);
         rd_chk(ADDR_RESET_CAUSE, d & 8'hdf);
      end
      cmp({7'h00, core_reset_o}, 8'h00);
      cfg_i.brownout_mode_cfg <= BOR_MODE_ON;
      cfg_i.low_power_brownout_en <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         e = '0;
         case (i)
            0: e.reset_instr = 1'b1;
            1: e.stack_overflow = 1'b1;
            2: e.stack_underflow = 1'b1;
            3: e.watchdog_timeout = 1'b1;
            4: e.bor_trip = 1'b1;
            5: e.low_power_brownout_trip = 1'b1;
            default: e.por = 1'b1;
         endcase
         wr_reg(ADDR_RESET_CAUSE, 8'h1f);
         hold(e);
         rd_chk(ADDR_RESET_CAUSE, exp_c[i]);
         rd_chk(ADDR_STATUS, exp_s[i]);
      end
      e = '0;
      e.prog_exit = 1'b1;
      hold(e);
      ext_reset_pin_i <= 1'b0;
      step(4);
      ext_reset_pin_i <= 1'b1;
      step(20);
      cmp({7'h00, cpu_run_o}, 8'h01);
      for (int i = 0; i < 3; i++)
      begin
         cfg_i.ext_reset_pin_enable <= (i == 0);
         cfg_i.low_voltage_prog_enable <= (i == 1);
         wr_reg(ADDR_RESET_CAUSE, 8'h1f);
         ext_reset_pin_i <= 1'b0;
         step(30);
         cmp({7'h00, core_reset_o}, {7'h00, i != 2});
         ext_reset_pin_i <= 1'b1;
         step(1);
         wait_run();
         cmp(8'(n >= RELEASE_CYCLES - 1 || i == 2), 8'h01);
         rd_chk(ADDR_RESET_CAUSE, i == 2 ? 8'h1f : 8'h17);
      end
      wr_reg(ADDR_CONFIG, 8'h00);
      step(1);
      cmp({7'h00, pin_pullup_o}, 8'h00);
      wr_reg(ADDR_CONFIG, 8'h01);
      step(1);
      cmp({7'h00, pin_pullup_o}, 8'h01);
      cfg_i.low_power_brownout_en <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         cfg_i.brownout_mode_cfg <= modes[i][4:3];
         wr_reg(ADDR_BROWNOUT_CTRL, {modes[i][2], 7'h00});
         evt_i.sleep <= modes[i][1];
         step(6);
         cmp({7'h00, bor_active_o}, {7'h00, modes[i][0]});
         evt_i.sleep <= 1'b0;
         // Wake again so the next mode starts awake
         evt_i.wake_irq <= modes[i][1];
         step(1);
         evt_i.wake_irq <= 1'b0;
         step(5);
         cmp({7'h00, cpu_run_o}, 8'h01);
      end
      cfg_i.brownout_mode_cfg <= BOR_MODE_SW;
      wr_reg(ADDR_BROWNOUT_CTRL, 8'h80);
      rd_chk(ADDR_BROWNOUT_CTRL, 8'h81);
      give_verdict();
   end
endmodule // rss_reset_source_sequencer_bench
`default_nettype wire
